/* shared/fcfg_pkg.sv */
// Constants for the FIFO flag configuration register bank
package fcfg_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned OFFS_W = 10;
   localparam logic [3:0] FIRST_ADDR = 4'h1;
   localparam logic [3:0] LAST_ADDR = 4'hA;
   localparam logic [3:0] ADDR_RSVD_ONE = 4'h1;
   localparam logic [3:0] ADDR_RSVD_TWO = 4'h2;
   localparam logic [3:0] ADDR_RSVD_THREE = 4'h3;
   localparam logic [3:0] ADDR_AE_LOW = 4'h4;
   localparam logic [3:0] ADDR_AE_HIGH = 4'h5;
   localparam logic [3:0] ADDR_RSVD_SIX = 4'h6;
   localparam logic [3:0] ADDR_AF_LOW = 4'h7;
   localparam logic [3:0] ADDR_AF_HIGH = 4'h8;
   localparam logic [3:0] ADDR_RSVD_NINE = 4'h9;
   localparam logic [3:0] ADDR_CLK_RATIO = 4'hA;
   localparam logic [3:0] SEQ_START = 4'hA;
   localparam logic [7:0] RST_AE_LOW = 8'h7F;
   localparam logic [7:0] RST_AE_HIGH = 8'h00;
   localparam logic [7:0] RST_AF_LOW = 8'h7F;
   localparam logic [7:0] RST_AF_HIGH = 8'h00;
   localparam logic [7:0] RST_RSVD = 8'h00;
   localparam logic [7:0] RST_CLK_RATIO = 8'h80;
   localparam int unsigned FAST_BIT = 7;
   localparam int unsigned HIGH_BITS = 2;
   localparam logic [9:0] WRITABLE_MASK = 10'h2D8;
   localparam logic [3:0] SETTLE_CYCLES = 4'h8;
   localparam logic [8:0] RATE_TERMINAL = 9'h100;
   localparam logic [3:0] SER_FRAME_BITS = 4'hC;
endpackage : fcfg_pkg

/* src/fcfg_serial_load.sv */
// Serial loader: shifts address and data frames into a register write
`timescale 1ns/1ps
module fcfg_serial_load (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic sclk_rise,
   input wire logic sdata,
   output logic wr_en,
   output logic [3:0] wr_addr,
   output logic [7:0] wr_data
);
   logic [11:0] shift_reg;
   logic [3:0] count_reg;
   wire logic [11:0] shift_next = {shift_reg[10:0], sdata};
   wire logic frame_end = enable && sclk_rise && (count_reg == fcfg_pkg::SER_FRAME_BITS - 4'h1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= 12'h000;
         count_reg <= 4'h0;
      end else if (!enable) begin
         count_reg <= 4'h0;
      end else if (sclk_rise) begin
         shift_reg <= shift_next;
         count_reg <= frame_end ? 4'h0 : count_reg + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_en <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 8'h00;
      end else begin
         wr_en <= frame_end;
         wr_addr <= shift_next[11:8];
         wr_data <= shift_next[7:0];
      end
   end
endmodule : fcfg_serial_load

/* src/fcfg_regs.sv */
// FIFO flag configuration register bank with parallel and serial loading
//
// Behaviour
// - Ten eight-bit registers, sequential addresses.
// - Almost-empty at 0x4, almost-full at 0x7.
// - Serial select low with config-load high enables serial writes.
// - Serial uses own clock and data pins.
// - Config-load low routes ports to registers.
// - Config-load high: FIFO writes, parallel register writes blocked.
// - Parallel sequence starts at 0xA, steps.
// - Parallel readback in either programming mode.
// - No serial readback path exists.
// - Programming allowed any time after reset.
// - Sequence wraps to first after last.
// - New values act after eight write clocks.
// - Fast-clock bit is 0xA bit 7, default 1.
// - Write edges walk registers, eleventh wraps.
// - Read edges walk registers, eleventh wraps.
// - Load high, write request low stores word.
// - Load high, read request low fetches word.
// - Rate evaluation sets fast bit; software overrides.
`timescale 1ns/1ps
module fcfg_regs (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic serial_load_select_n,
   input wire logic config_load_n,
   input wire logic wr_clk_in,
   input wire logic rd_clk_in,
   input wire logic wr_req_n,
   input wire logic rd_req_n,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] fifo_rd_data,
   input wire logic serial_clk,
   input wire logic serial_in,
   output logic [7:0] rd_data,
   output logic fifo_wr_strobe,
   output logic [7:0] fifo_wr_data,
   output logic fifo_rd_strobe,
   output logic [9:0] almost_empty_offset,
   output logic [9:0] almost_full_offset,
   output logic fast_clk_write
);
   logic rst_sync1_reg;
   logic rst_sync2_reg;
   wire logic rst_n = rst_sync2_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end

   // Edge detection of the port clocks
   logic wr_clk_prev_reg;
   logic rd_clk_prev_reg;
   logic sclk_prev_reg;
   wire logic wr_rise = wr_clk_in && !wr_clk_prev_reg;
   wire logic rd_rise = rd_clk_in && !rd_clk_prev_reg;
   wire logic sclk_rise = serial_clk && !sclk_prev_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_clk_prev_reg <= 1'b0;
         rd_clk_prev_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end else begin
         wr_clk_prev_reg <= wr_clk_in;
         rd_clk_prev_reg <= rd_clk_in;
         sclk_prev_reg <= serial_clk;
      end
   end

   // Access decode
   wire logic cfg_sel = !config_load_n;
   wire logic par_wr = cfg_sel && serial_load_select_n && !wr_req_n && rd_req_n && wr_rise;
   wire logic par_rd = cfg_sel && !rd_req_n && wr_req_n && rd_rise;
   wire logic fifo_wr = config_load_n && !wr_req_n && wr_rise;
   wire logic fifo_rd = config_load_n && !rd_req_n && rd_rise;
   wire logic serial_en = !serial_load_select_n && config_load_n;

   // Serial loader
   logic ser_wr_en;
   logic [3:0] ser_wr_addr;
   logic [7:0] ser_wr_data;

   fcfg_serial_load u_serial (
      .clk(ref_clk),
      .rst_n(rst_n),
      .enable(serial_en),
      .sclk_rise(sclk_rise),
      .sdata(serial_in),
      .wr_en(ser_wr_en),
      .wr_addr(ser_wr_addr),
      .wr_data(ser_wr_data)
   );

   // Sequence pointers
   logic [3:0] wptr_reg;
   logic [3:0] rptr_reg;
   wire logic [3:0] wptr_step = (wptr_reg == fcfg_pkg::LAST_ADDR) ?
      fcfg_pkg::FIRST_ADDR : wptr_reg + 4'h1;
   wire logic [3:0] rptr_step = (rptr_reg == fcfg_pkg::LAST_ADDR) ?
      fcfg_pkg::FIRST_ADDR : rptr_reg + 4'h1;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_reg <= fcfg_pkg::SEQ_START;
         rptr_reg <= fcfg_pkg::SEQ_START;
      end else if (!cfg_sel) begin
         wptr_reg <= fcfg_pkg::SEQ_START;
         rptr_reg <= fcfg_pkg::SEQ_START;
      end else begin
         if (par_wr) begin
            wptr_reg <= wptr_step;
         end
         if (par_rd) begin
            rptr_reg <= rptr_step;
         end
      end
   end

   // Clock rate evaluation after reset
   logic [8:0] wr_rate_cnt_reg;
   logic [8:0] rd_rate_cnt_reg;
   logic eval_done_reg;
   wire logic wr_term = wr_rate_cnt_reg == fcfg_pkg::RATE_TERMINAL;
   wire logic rd_term = rd_rate_cnt_reg == fcfg_pkg::RATE_TERMINAL;
   wire logic eval_fire = !eval_done_reg && (wr_term || rd_term);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_rate_cnt_reg <= 9'h000;
         rd_rate_cnt_reg <= 9'h000;
         eval_done_reg <= 1'b0;
      end else if (!eval_done_reg) begin
         if (wr_rise && !wr_term) begin
            wr_rate_cnt_reg <= wr_rate_cnt_reg + 9'h001;
         end
         if (rd_rise && !rd_term) begin
            rd_rate_cnt_reg <= rd_rate_cnt_reg + 9'h001;
         end
         eval_done_reg <= wr_term || rd_term;
      end
   end

   // Register storage
   wire logic [3:0] wr_addr = par_wr ? wptr_reg : ser_wr_addr;
   wire logic [7:0] wr_value = par_wr ? wr_data : ser_wr_data;
   wire logic any_wr = par_wr || ser_wr_en;
   logic [7:0] cfg_reg [1:10];
   logic [7:0] cfg_next [1:10];
   logic [9:0] store_hit;

   genvar gi;
   generate
      for (gi = 1; gi <= 10; gi++) begin : g_reg
         localparam logic [3:0] IDX = 4'(gi);
         localparam logic [7:0] RST_VAL =
            (IDX == fcfg_pkg::ADDR_AE_LOW) ? fcfg_pkg::RST_AE_LOW :
            (IDX == fcfg_pkg::ADDR_AE_HIGH) ? fcfg_pkg::RST_AE_HIGH :
            (IDX == fcfg_pkg::ADDR_AF_LOW) ? fcfg_pkg::RST_AF_LOW :
            (IDX == fcfg_pkg::ADDR_AF_HIGH) ? fcfg_pkg::RST_AF_HIGH :
            (IDX == fcfg_pkg::ADDR_CLK_RATIO) ? fcfg_pkg::RST_CLK_RATIO :
            fcfg_pkg::RST_RSVD;
         localparam logic [7:0] KEEP_MASK =
            (IDX == fcfg_pkg::ADDR_CLK_RATIO) ? 8'h80 : 8'hFF;
         assign store_hit[gi-1] = any_wr && (wr_addr == IDX) &&
            fcfg_pkg::WRITABLE_MASK[gi-1];
         if (gi == 10) begin : g_fast
            assign cfg_next[gi] = store_hit[gi-1] ? (wr_value & KEEP_MASK) :
               eval_fire ? {wr_term, 7'h00} : cfg_reg[gi];
         end else begin : g_plain
            assign cfg_next[gi] = store_hit[gi-1] ? (wr_value & KEEP_MASK) : cfg_reg[gi];
         end
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               cfg_reg[gi] <= RST_VAL;
            end else begin
               cfg_reg[gi] <= cfg_next[gi];
            end
         end
      end
   endgenerate

   // Assembled offsets from stored registers
   wire logic [9:0] ae_stored = {cfg_reg[fcfg_pkg::ADDR_AE_HIGH][1:0],
      cfg_reg[fcfg_pkg::ADDR_AE_LOW]};
   wire logic [9:0] af_stored = {cfg_reg[fcfg_pkg::ADDR_AF_HIGH][1:0],
      cfg_reg[fcfg_pkg::ADDR_AF_LOW]};
   wire logic fast_stored = cfg_reg[fcfg_pkg::ADDR_CLK_RATIO][fcfg_pkg::FAST_BIT];

   // Settle delay before new values reach the flag logic
   logic [3:0] settle_cnt_reg;
   logic pending_reg;
   wire logic changed = (|store_hit) || eval_fire;
   wire logic apply = pending_reg && !changed && wr_rise && (settle_cnt_reg == 4'h1);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt_reg <= 4'h0;
         pending_reg <= 1'b0;
      end else if (changed) begin
         settle_cnt_reg <= fcfg_pkg::SETTLE_CYCLES;
         pending_reg <= 1'b1;
      end else if (pending_reg && wr_rise) begin
         settle_cnt_reg <= settle_cnt_reg - 4'h1;
         pending_reg <= settle_cnt_reg != 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         almost_empty_offset <= {fcfg_pkg::RST_AE_HIGH[1:0], fcfg_pkg::RST_AE_LOW};
         almost_full_offset <= {fcfg_pkg::RST_AF_HIGH[1:0], fcfg_pkg::RST_AF_LOW};
         fast_clk_write <= fcfg_pkg::RST_CLK_RATIO[fcfg_pkg::FAST_BIT];
      end else if (apply) begin
         almost_empty_offset <= ae_stored;
         almost_full_offset <= af_stored;
         fast_clk_write <= fast_stored;
      end
   end

   // Readback and FIFO port strobes
   wire logic [7:0] rd_reg_value = fcfg_pkg::WRITABLE_MASK[rptr_reg - 4'h1] ?
      cfg_reg[rptr_reg] : fcfg_pkg::RST_RSVD;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         fifo_wr_strobe <= 1'b0;
         fifo_wr_data <= 8'h00;
         fifo_rd_strobe <= 1'b0;
      end else begin
         fifo_wr_strobe <= fifo_wr;
         fifo_rd_strobe <= fifo_rd;
         if (fifo_wr) begin
            fifo_wr_data <= wr_data;
         end
         if (par_rd) begin
            rd_data <= rd_reg_value;
         end else if (fifo_rd) begin
            rd_data <= fifo_rd_data;
         end
      end
   end
endmodule : fcfg_regs

/* tb/fcfg_regs_chk.sv */
// Port assertions for the register bank
`timescale 1ns/1ps
module fcfg_regs_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic config_load_n,
   input wire logic wr_clk_in,
   input wire logic rd_clk_in,
   input wire logic wr_req_n,
   input wire logic rd_req_n,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic fifo_wr_strobe,
   input wire logic [7:0] fifo_wr_data,
   input wire logic fifo_rd_strobe,
   input wire logic [9:0] almost_empty_offset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_wr_cause; $rose(wr_clk_in) && config_load_n && !wr_req_n
      |=> fifo_wr_strobe && fifo_wr_data == $past(wr_data); endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("fifo write lost");
   property p_rd_cause; $rose(rd_clk_in) && config_load_n && !rd_req_n |=> fifo_rd_strobe;
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("fifo read lost");
   property p_wr_pulse; fifo_wr_strobe |=> !fifo_wr_strobe; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe long");
   property p_rd_pulse; fifo_rd_strobe |=> !fifo_rd_strobe; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe long");
   property p_wr_src; fifo_wr_strobe |-> $past(config_load_n) && !$past(wr_req_n); endproperty
   a_wr_src: assert property (p_wr_src) else $error("stray fifo write");
   property p_cfg_quiet; !config_load_n |=> !fifo_wr_strobe && !fifo_rd_strobe; endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("fifo hit in config");
   property p_rd_hold; $changed(rd_data) |-> $past(rd_clk_in) && !$past(rd_clk_in, 2);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_ae_apply; $changed(almost_empty_offset) |-> $past(wr_clk_in) || $past(wr_clk_in, 2);
   endproperty
   a_ae_apply: assert property (p_ae_apply) else $error("offset off clock");
endmodule : fcfg_regs_chk

/* tb/fcfg_fifo_model.sv */
// Behavioural FIFO memory beside the bank
`timescale 1ns/1ps
module fcfg_fifo_model (
   input wire logic ref_clk,
   input wire logic fifo_wr_strobe,
   input wire logic [7:0] fifo_wr_data,
   input wire logic fifo_rd_strobe,
   output logic [7:0] fifo_rd_data,
   output logic [7:0] wr_cnt = 8'h00,
   output logic [7:0] rd_cnt = 8'h00
);
   logic [7:0] mem [0:15];
   assign fifo_rd_data = mem[rd_cnt[3:0]];
   always @(posedge ref_clk) begin
      if (fifo_wr_strobe) mem[wr_cnt[3:0]] <= fifo_wr_data;
      if (fifo_wr_strobe) wr_cnt <= wr_cnt + 8'h01;
      if (fifo_rd_strobe) rd_cnt <= rd_cnt + 8'h01;
   end
endmodule : fcfg_fifo_model

/* tb/test_fifo_flag_config_registers.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
module test_fifo_flag_config_registers;
   logic ref_clk = 1'b0, rstn = 1'b0, sel_n = 1'b1, cfg_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
   logic wck = 1'b0, rck = 1'b0, sck = 1'b0, sin = 1'b0, fws, frs, fcw;
   logic [7:0] wdat = 8'h00, v, rdat, fwd, frd, wcnt, rcnt;
   logic [9:0] aeo, afo;
   logic [7:0] exp_reg [1:10];
   logic [7:0] fw [0:7];
   int error_cnt = 0, checks_done = 0, i;
   fcfg_regs u_dut (.ref_clk(ref_clk), .rstn(rstn), .serial_load_select_n(sel_n),
      .config_load_n(cfg_n), .wr_clk_in(wck), .rd_clk_in(rck), .wr_req_n(wr_n),
      .rd_req_n(rd_n), .wr_data(wdat), .fifo_rd_data(frd), .serial_clk(sck),
      .serial_in(sin), .rd_data(rdat), .fifo_wr_strobe(fws), .fifo_wr_data(fwd),
      .fifo_rd_strobe(frs), .almost_empty_offset(aeo), .almost_full_offset(afo),
      .fast_clk_write(fcw));
   fcfg_fifo_model u_mem (.ref_clk(ref_clk), .fifo_wr_strobe(fws), .fifo_wr_data(fwd),
      .fifo_rd_strobe(frs), .fifo_rd_data(frd), .wr_cnt(wcnt), .rd_cnt(rcnt));
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      #150000;
      error_cnt++;
      wrap_up();
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : tick
   task automatic pulse(input logic w);
      wck = w;
      rck = !w;
      tick(2);
      wck = 1'b0;
      rck = 1'b0;
      tick(2);
   endtask : pulse
   task automatic ser(input logic [11:0] f);
      for (int b = 11; b >= 0; b--) begin
         sin = f[b];
         tick(1);
         sck = 1'b1;
         tick(2);
         sck = 1'b0;
      end
   endtask : ser
   task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] s);
      checks_done++;
      if (e !== s) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : cmp
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   function automatic int sa(input int k);
      return (k % 10 == 0) ? 10 : k;
   endfunction : sa
   function automatic logic [7:0] kept(input int a, input logic [7:0] d);
      if (a == 10) return d & 8'h80;
      return (a == 4 || a == 5 || a == 7 || a == 8) ? d : 8'h00;
   endfunction : kept
   initial begin
      i = $urandom(32'h2d90);
      tick(4);
      rstn = 1'b1;
      tick(4);
      cmp("ae_offset", 10'h07F, aeo);
      cmp("af_offset", 10'h07F, afo);
      cmp("fast_bit", 10'h001, fcw);
      $display("reset test done");
      cfg_n = 1'b0;
      wr_n = 1'b0;
      for (i = 0; i < 11; i++) begin
         v = (i == 4) ? 8'hFF : (i == 5) ? 8'h03 : 8'($urandom);
         if (i == 8) v = v & 8'h03;
         if (i == 10) v[7] = ~exp_reg[10][7];
         wdat = v;
         exp_reg[sa(i)] = kept(sa(i), v);
         pulse(1'b1);
      end
      $display("config write test done");
      cfg_n = 1'b1;
      for (i = 0; i < 8; i++) begin
         if (i == 7) cmp("ae_early", 10'h07F, aeo);
         wdat = 8'($urandom);
         fw[i] = wdat;
         pulse(1'b1);
         cmp("fifo_data", wdat, fwd);
      end
      cmp("ae_offset", {exp_reg[5][1:0], exp_reg[4]}, aeo);
      cmp("af_offset", {exp_reg[8][1:0], exp_reg[7]}, afo);
      cmp("fast_bit", exp_reg[10][7], fcw);
      cmp("fifo_writes", 8'h08, wcnt);
      wr_n = 1'b1;
      rd_n = 1'b0;
      pulse(1'b0);
      cmp("fifo_rd_data", fw[0], rdat);
      pulse(1'b0);
      cmp("fifo_rd_data", fw[1], rdat);
      cmp("fifo_reads", 8'h02, rcnt);
      $display("fifo test done");
      rd_n = 1'b1;
      sel_n = 1'b0;
      v = 8'($urandom);
      ser({4'h7, v});
      exp_reg[7] = v;
      sel_n = 1'b1;
      tick(4);
      cfg_n = 1'b0;
      rd_n = 1'b0;
      for (i = 0; i < 11; i++) begin
         pulse(1'b0);
         cmp("reg_read", exp_reg[sa(i)], rdat);
      end
      $display("readback test done");
      rd_n = 1'b1;
      cfg_n = 1'b1;
      tick(2);
      rstn = 1'b0;
      tick(4);
      rstn = 1'b1;
      tick(4);
      cmp("ae_offset", 10'h07F, aeo);
      cmp("fast_bit", 10'h001, fcw);
      for (i = 0; i < 256; i++) begin
         pulse(1'b0);
      end
      for (i = 0; i < 8; i++) begin
         pulse(1'b1);
      end
      cmp("fast_bit", 10'h000, fcw);
      cfg_n = 1'b0;
      rd_n = 1'b0;
      pulse(1'b0);
      cmp("reg_read", 10'h000, rdat);
      $display("rate test done");
      rd_n = 1'b1;
      cfg_n = 1'b1;
      tick(2);
      wrap_up();
   end
endmodule : test_fifo_flag_config_registers
bind fcfg_regs fcfg_regs_chk u_chk (.ref_clk, .rstn, .config_load_n, .wr_clk_in,
   .rd_clk_in, .wr_req_n, .rd_req_n, .wr_data, .rd_data, .fifo_wr_strobe, .fifo_wr_data,
   .fifo_rd_strobe, .almost_empty_offset);
